// >>> verilog/fct_pkg.sv
// Constants and carrier types of the fixed-cycle countdown timer.
// Assumes one 250 MHz core clock; all addresses are 4-bit register indices.
package fct_pkg;

  ////////////////////////////////////////////////////////////////////////////
  // Timing
  localparam int unsigned CLK_PERIOD_NS = 4;
  // Auto release with the fast source: 122 us
  localparam int unsigned REL_FAST_NS   = 122000;
  // Auto release with every other source: 7.8125 ms
  localparam int unsigned REL_SLOW_NS   = 7812500;
  // Longest times, so division rounds down
  localparam int unsigned REL_FAST_CYC  = REL_FAST_NS / CLK_PERIOD_NS;
  localparam int unsigned REL_SLOW_CYC  = REL_SLOW_NS / CLK_PERIOD_NS;
  localparam int unsigned REL_W         = 21;

  ////////////////////////////////////////////////////////////////////////////
  // Register indices
  localparam logic [3:0] ADDR_PRESET_LO = 4'hB;
  localparam logic [3:0] ADDR_PRESET_HI = 4'hC;
  localparam logic [3:0] ADDR_EXT       = 4'hD;
  localparam logic [3:0] ADDR_FLAG      = 4'hE;
  localparam logic [3:0] ADDR_CTRL      = 4'hF;

  // Field positions
  localparam int unsigned EXT_SEL_LO_BIT  = 0;
  localparam int unsigned EXT_SEL_HI_BIT  = 1;
  localparam int unsigned EXT_RUN_BIT     = 4;
  localparam int unsigned FLAG_EVENT_BIT  = 4;
  localparam int unsigned CTRL_IRQ_EN_BIT = 4;
  localparam int unsigned CTRL_CLK_RST_BIT = 0;
  localparam int unsigned PRESET_W       = 12;
  localparam int unsigned HI_PRESET_W    = 4;

  // Source select codes
  localparam logic [1:0] SEL_4096 = 2'h0;
  localparam logic [1:0] SEL_64   = 2'h1;
  localparam logic [1:0] SEL_SEC  = 2'h2;
  localparam logic [1:0] SEL_MIN  = 2'h3;

  // Reset values and counter constants
  localparam logic [7:0]  REG_RST   = 8'h00;
  localparam logic [1:0]  SEL_RST   = 2'h0;
  localparam logic [11:0] CNT_LAST  = 12'h001;
  localparam logic [11:0] CNT_ZERO  = 12'h000;
  localparam logic [11:0] CNT_STEP  = 12'h001;

  ////////////////////////////////////////////////////////////////////////////
  // Carriers
  // One-cycle strobes from the timekeeping divider chain
  typedef struct packed {
    logic tick_4096;
    logic tick_64;
    logic tick_sec;
    logic tick_min;
  } fct_ticks_t;

  // Register write request from the serial front end
  typedef struct packed {
    logic       en;
    logic [3:0] addr;
    logic [7:0] data;
  } fct_wr_t;

endpackage

// >>> verilog/fct_timer.sv
// Fixed-cycle countdown timer with its registers and shared interrupt drive.
// Assumes the serial front end presents decoded writes and read addresses on
// i_ref_clk, and the divider chain gives one-cycle source strobes.
`timescale 1ns/100ps

// Operation
// R1: Two-bit select picks 4096Hz, 64Hz, second, minute
// R2: Interrupt low 122us fast source, else 7.8125ms
// R3: Clock reset bit stops all but 4096Hz
// R4: Twelve-bit preset split over two registers
// R5: Decrement per tick, event on 001h to 000h
// R6: Reload preset after event, keep repeating
// R7: Start from preset on each run rising
// R8: Host stops timer before changing preset
// R9: Writing run zero stops; run bit readable
// R10: Run cleared releases held interrupt output
// R11: Flag sticky until written zero; one ignored
// R12: Clearing flag releases held interrupt output
// R13: Enable one drives low; zero leaves released
// R14: Enable cleared releases held interrupt output
// R15: Output shared; other sources still drive low
// R16: Second and minute steps follow update instants
// R17: First interval within one source period short
// R18: Countdown starts on serial clock rising edge
// R19: Upper preset nibble is plain storage
// R20: Zero preset never produces an event
// R21: Sources come synchronously from divider chain
module fct_timer #(
  parameter int unsigned REL_FAST_CYC = fct_pkg::REL_FAST_CYC,
  parameter int unsigned REL_SLOW_CYC = fct_pkg::REL_SLOW_CYC
) (
  // Clock and reset
  input  wire logic               i_ref_clk,
  input  wire logic               i_sys_rst,
  // Timekeeping strobes
  input  wire fct_pkg::fct_ticks_t i_ticks,
  // Serial link clock and decoded register access
  input  wire logic               i_ser_clk,
  input  wire fct_pkg::fct_wr_t   i_wr,
  input  wire logic [3:0]         i_rd_addr,
  output logic [7:0]              o_rd_data,
  // Other interrupt sources sharing the pin
  input  wire logic               i_other_int_low,
  // Open-drain interrupt pin, active low
  output logic                    o_int_n_o,
  output logic                    o_int_n_oe
);

  ////////////////////////////////////////////////////////////////////////////
  // Elaboration checks

  // Release counter must hold both counts and neither may be zero
  if (REL_FAST_CYC < 1 || REL_SLOW_CYC < 1 ||
      REL_FAST_CYC >= (64'h1 << fct_pkg::REL_W) ||
      REL_SLOW_CYC >= (64'h1 << fct_pkg::REL_W)) begin : g_bad_rel
    $error("fct_timer: release count out of range");
  end

  ////////////////////////////////////////////////////////////////////////////
  // Functions

  // Is this cycle a write to the given register
  function automatic logic is_wr(input fct_pkg::fct_wr_t wr,
                                 input logic [3:0] addr);
    is_wr = wr.en && (wr.addr == addr);
  endfunction

  // Strobe of the selected source, gated by the clock reset bit except for 4096Hz
  function automatic logic src_tick(input logic [1:0] sel,
                                    input fct_pkg::fct_ticks_t t,
                                    input logic clk_rst);
    case (sel)
      fct_pkg::SEL_4096: src_tick = t.tick_4096;            // see R1
      fct_pkg::SEL_64:   src_tick = t.tick_64 && !clk_rst;  // see R3
      fct_pkg::SEL_SEC:  src_tick = t.tick_sec && !clk_rst; // see R16
      fct_pkg::SEL_MIN:  src_tick = t.tick_min && !clk_rst; // see R16
      default:           src_tick = 1'b0;
    endcase
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  // Declarations

  typedef enum logic [1:0] {
    ST_STOP,
    ST_ARMED,
    ST_RUN
  } fct_state_t;

  fct_state_t                     state_q;
  logic [7:0]                     preset_lo_q;
  logic [7:0]                     preset_hi_q;
  logic [1:0]                     sel_q;
  logic                           run_q;
  logic                           flag_q;
  logic                           irq_en_q;
  logic                           clk_rst_q;
  logic [fct_pkg::PRESET_W-1:0]   cnt_q;
  logic                           hold_q;
  logic [fct_pkg::REL_W-1:0]      rel_q;
  logic                           sclk_meta_q;
  logic                           sclk_sync_q;
  logic                           sclk_prev_q;
  logic [7:0]                     rd_d;

  logic                           wr_ext;
  logic                           wr_flag;
  logic                           wr_ctrl;
  logic                           run_set;
  logic                           run_clr;
  logic                           flag_clr;
  logic                           irq_en_clr;
  logic                           sclk_rise;
  logic                           step;
  logic                           event_hit;
  logic                           start;
  logic [fct_pkg::PRESET_W-1:0]   preset;

  ////////////////////////////////////////////////////////////////////////////
  // Write decode

  // Register hits and the control effects of each write
  assign wr_ext     = is_wr(i_wr, fct_pkg::ADDR_EXT);
  assign wr_flag    = is_wr(i_wr, fct_pkg::ADDR_FLAG);
  assign wr_ctrl    = is_wr(i_wr, fct_pkg::ADDR_CTRL);
  assign run_set    = wr_ext && i_wr.data[fct_pkg::EXT_RUN_BIT] && !run_q;
  assign run_clr    = wr_ext && !i_wr.data[fct_pkg::EXT_RUN_BIT];      // see R9
  assign flag_clr   = wr_flag && !i_wr.data[fct_pkg::FLAG_EVENT_BIT];  // see R11
  assign irq_en_clr = wr_ctrl && !i_wr.data[fct_pkg::CTRL_IRQ_EN_BIT];

  // Upper nibble of the high preset register is not counted
  assign preset = {preset_hi_q[fct_pkg::HI_PRESET_W-1:0], preset_lo_q}; // see R4

  ////////////////////////////////////////////////////////////////////////////
  // Serial clock sampling

  // Two stages before use; edge found between second and third
  always_ff @(posedge i_ref_clk) begin
    if (i_sys_rst) begin
      sclk_meta_q <= 1'b0;
      sclk_sync_q <= 1'b0;
      sclk_prev_q <= 1'b0;
    end else begin
      sclk_meta_q <= i_ser_clk;
      sclk_sync_q <= sclk_meta_q;
      sclk_prev_q <= sclk_sync_q;
    end
  end

  assign sclk_rise = sclk_sync_q && !sclk_prev_q;

  ////////////////////////////////////////////////////////////////////////////
  // Configuration registers

  // Preset bytes; host keeps the timer stopped while writing them
  always_ff @(posedge i_ref_clk) begin
    if (i_sys_rst) begin
      preset_lo_q <= fct_pkg::REG_RST;
      preset_hi_q <= fct_pkg::REG_RST;
    end else begin
      if (is_wr(i_wr, fct_pkg::ADDR_PRESET_LO)) begin  // see R4, R8
        preset_lo_q <= i_wr.data;
      end
      if (is_wr(i_wr, fct_pkg::ADDR_PRESET_HI)) begin  // see R19
        preset_hi_q <= i_wr.data;
      end
    end
  end

  // Source select and run bit
  always_ff @(posedge i_ref_clk) begin
    if (i_sys_rst) begin
      sel_q <= fct_pkg::SEL_RST;
      run_q <= 1'b0;
    end else if (wr_ext) begin
      sel_q <= {i_wr.data[fct_pkg::EXT_SEL_HI_BIT],
                i_wr.data[fct_pkg::EXT_SEL_LO_BIT]};   // see R1
      run_q <= i_wr.data[fct_pkg::EXT_RUN_BIT];        // see R9
    end
  end

  // Interrupt enable and clock reset bits
  always_ff @(posedge i_ref_clk) begin
    if (i_sys_rst) begin
      irq_en_q  <= 1'b0;
      clk_rst_q <= 1'b0;
    end else if (wr_ctrl) begin
      irq_en_q  <= i_wr.data[fct_pkg::CTRL_IRQ_EN_BIT];
      clk_rst_q <= i_wr.data[fct_pkg::CTRL_CLK_RST_BIT];
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Run control

  // A rising run bit arms; counting starts on the next serial clock rise
  always_ff @(posedge i_ref_clk) begin
    if (i_sys_rst) begin
      state_q <= ST_STOP;
    end else if (run_clr) begin
      state_q <= ST_STOP;                              // see R9
    end else begin
      case (state_q)
        ST_STOP: begin
          if (run_set) begin
            state_q <= ST_ARMED;                       // see R7
          end
        end
        ST_ARMED: begin
          if (sclk_rise) begin
            state_q <= ST_RUN;                         // see R18
          end
        end
        ST_RUN: begin
          state_q <= ST_RUN;
        end
        default: begin
          state_q <= ST_STOP;
        end
      endcase
    end
  end

  assign start = (state_q == ST_ARMED) && sclk_rise && !run_clr;
  // Ticks arrive at any phase, so the first interval may be short
  assign step  = (state_q == ST_RUN) && !run_clr &&
                 src_tick(sel_q, i_ticks, clk_rst_q);  // see R17, R21
  // A zero count never reaches the last step
  assign event_hit = step && (cnt_q == fct_pkg::CNT_LAST); // see R5, R20

  ////////////////////////////////////////////////////////////////////////////
  // Down-counter

  // Loads on start, reloads after each event, parks at zero
  always_ff @(posedge i_ref_clk) begin
    if (i_sys_rst) begin
      cnt_q <= fct_pkg::CNT_ZERO;
    end else if (start) begin
      cnt_q <= preset;                                 // see R7
    end else if (event_hit) begin
      cnt_q <= preset;                                 // see R6
    end else if (step && cnt_q != fct_pkg::CNT_ZERO) begin
      cnt_q <= cnt_q - fct_pkg::CNT_STEP;              // see R5
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Event flag

  // Set wins over a clear in the same cycle; writing one does nothing
  always_ff @(posedge i_ref_clk) begin
    if (i_sys_rst) begin
      flag_q <= 1'b0;
    end else if (event_hit) begin
      flag_q <= 1'b1;                                  // see R11
    end else if (flag_clr) begin
      flag_q <= 1'b0;                                  // see R11
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Interrupt hold and auto release

  // A new event restarts the release time even during a clear
  always_ff @(posedge i_ref_clk) begin
    if (i_sys_rst) begin
      hold_q <= 1'b0;
      rel_q  <= '0;
    end else if (event_hit && irq_en_q) begin
      hold_q <= 1'b1;                                  // see R13
      rel_q  <= (sel_q == fct_pkg::SEL_4096) ?
                fct_pkg::REL_W'(REL_FAST_CYC) :
                fct_pkg::REL_W'(REL_SLOW_CYC);         // see R2
    end else if (hold_q) begin
      if (run_clr || flag_clr || irq_en_clr) begin
        hold_q <= 1'b0;                                // see R10, R12, R14
        rel_q  <= '0;
      end else if (rel_q == fct_pkg::REL_W'(1)) begin
        hold_q <= 1'b0;                                // see R2
        rel_q  <= '0;
      end else begin
        rel_q  <= rel_q - fct_pkg::REL_W'(1);
      end
    end
  end

  // Pin pulled low by either this timer or any other source
  always_ff @(posedge i_ref_clk) begin
    if (i_sys_rst) begin
      o_int_n_o  <= 1'b0;
      o_int_n_oe <= 1'b0;
    end else begin
      o_int_n_o  <= 1'b0;                              // Open drain only pulls low
      o_int_n_oe <= hold_q || i_other_int_low;         // see R15
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Read path

  // Unlisted addresses and unused bits read zero
  always_comb begin
    rd_d = 8'h00;
    case (i_rd_addr)
      fct_pkg::ADDR_PRESET_LO: rd_d = preset_lo_q;
      fct_pkg::ADDR_PRESET_HI: rd_d = preset_hi_q;     // see R19
      fct_pkg::ADDR_EXT: begin
        rd_d[fct_pkg::EXT_RUN_BIT]    = run_q;         // see R9
        rd_d[fct_pkg::EXT_SEL_HI_BIT] = sel_q[1];
        rd_d[fct_pkg::EXT_SEL_LO_BIT] = sel_q[0];
      end
      fct_pkg::ADDR_FLAG: rd_d[fct_pkg::FLAG_EVENT_BIT] = flag_q;
      fct_pkg::ADDR_CTRL: begin
        rd_d[fct_pkg::CTRL_IRQ_EN_BIT]  = irq_en_q;
        rd_d[fct_pkg::CTRL_CLK_RST_BIT] = clk_rst_q;
      end
      default: rd_d = 8'h00;
    endcase
  end

  // Read data registered one cycle after the address
  always_ff @(posedge i_ref_clk) begin
    if (i_sys_rst) begin
      o_rd_data <= 8'h00;
    end else begin
      o_rd_data <= rd_d;
    end
  end

endmodule

// >>> testbench/fct_host_model.sv
// Host side of the serial link: makes the bit clock of one register frame.
// Assumes the bench says when a frame goes out; data bits are not modelled.
`timescale 1ns/100ps
module fct_host_model (
  // Frame request
  input  wire logic i_go,
  // Serial bit clock, idle low between frames
  output logic      o_ser_clk
);
  initial o_ser_clk = 1'b0;
  // Eight bit clocks at 80 ns; the last fall ends the frame
  always @(posedge i_go) begin
    repeat (8) begin
      #40 o_ser_clk = 1'b1;
      #40 o_ser_clk = 1'b0;
    end
  end
endmodule

// >>> testbench/fct_timer_sva.sv
// Port assertions for the fixed-cycle countdown timer.
// Assumes one clock domain and write requests as one-cycle pulses.
`timescale 1ns/100ps
module fct_timer_sva #(
  parameter int unsigned REL_FAST_CYC = 5,
  parameter int unsigned REL_SLOW_CYC = 20
) (
  // Clock and reset
  input wire logic                i_ref_clk,
  input wire logic                i_sys_rst,
  // Watched ports
  input wire fct_pkg::fct_ticks_t i_ticks,
  input wire logic                i_ser_clk,
  input wire fct_pkg::fct_wr_t    i_wr,
  input wire logic [3:0]          i_rd_addr,
  input wire logic [7:0]          o_rd_data,
  input wire logic                i_other_int_low,
  input wire logic                o_int_n_o,
  input wire logic                o_int_n_oe
);
  default clocking @(posedge i_ref_clk); endclocking
  default disable iff (i_sys_rst);
  logic [1:0]  sel_q;
  logic [21:0] hi_q;
  logic        quiet;
  logic        wr_off;
  ////////////////////////////////
  // No strobe and no other source, so only this timer moves the pin
  assign quiet  = (i_ticks == 4'h0) && !i_other_int_low;
  assign wr_off = i_wr.en && !i_wr.data[4] && quiet;
  // Shadow of the source select
  always_ff @(posedge i_ref_clk) begin
    if (i_sys_rst) begin
      sel_q <= 2'h0;
    end else if (i_wr.en && i_wr.addr == fct_pkg::ADDR_EXT) begin
      sel_q <= i_wr.data[1:0];
    end
  end
  // Length of the low drive; any strobe restarts it, which only loosens the bound
  always_ff @(posedge i_ref_clk) begin
    if (i_sys_rst || !o_int_n_oe || !quiet) begin
      hi_q <= 22'h0;
    end else begin
      hi_q <= hi_q + 22'h1;
    end
  end
  ////////////////////////////////
  a_pin_value_low: assert property (o_int_n_o == 1'b0)
    else $error("interrupt pin value not low");
  a_other_pulls: assert property (i_other_int_low |=> o_int_n_oe)
    else $error("other source did not pull the pin");
  a_flag_clear_rel: assert property ((wr_off && i_wr.addr == fct_pkg::ADDR_FLAG)
    ##1 !i_other_int_low |=> !o_int_n_oe) else $error("flag clear kept pin low");
  a_irq_off_rel: assert property ((wr_off && i_wr.addr == fct_pkg::ADDR_CTRL)
    ##1 !i_other_int_low |=> !o_int_n_oe) else $error("enable clear kept pin low");
  a_run_off_rel: assert property ((wr_off && i_wr.addr == fct_pkg::ADDR_EXT)
    ##1 !i_other_int_low |=> !o_int_n_oe) else $error("stop kept pin low");
  a_release_time: assert property (o_int_n_oe |-> hi_q <=
    ((sel_q == fct_pkg::SEL_4096) ? 22'(REL_FAST_CYC) : 22'(REL_SLOW_CYC)))
    else $error("pin held low too long");
  a_pin_has_cause: assert property ($rose(o_int_n_oe) |->
    $past(i_other_int_low) || $past(i_ticks != 4'h0, 2)) else $error("pin low without cause");
  a_rd_unmapped: assert property ((i_rd_addr < fct_pkg::ADDR_PRESET_LO)
    |=> o_rd_data == 8'h00) else $error("unmapped read not zero");
  a_nibble_store: assert property ((i_wr.en && i_wr.addr == fct_pkg::ADDR_PRESET_HI)
    ##1 !i_wr.en ##1 (!i_wr.en && i_rd_addr == fct_pkg::ADDR_PRESET_HI)
    |=> o_rd_data == $past(i_wr.data, 3)) else $error("preset high byte not stored");
endmodule

bind fct_timer fct_timer_sva #(
  .REL_FAST_CYC(REL_FAST_CYC),
  .REL_SLOW_CYC(REL_SLOW_CYC)
) u_sva (
  .i_ref_clk(i_ref_clk), .i_sys_rst(i_sys_rst), .i_ticks(i_ticks),
  .i_ser_clk(i_ser_clk), .i_wr(i_wr), .i_rd_addr(i_rd_addr),
  .o_rd_data(o_rd_data), .i_other_int_low(i_other_int_low),
  .o_int_n_o(o_int_n_o), .o_int_n_oe(o_int_n_oe)
);

// >>> testbench/fct_timer_tb.sv
// Self-checking bench for the fixed-cycle countdown timer.
// Assumes the host model gives serial frames; the bench drives all else.
`timescale 1ns/100ps
module fct_timer_tb;
  localparam int unsigned FAST = 12;
  localparam int unsigned SLOW = 40;
  logic                clk = 1'b0;
  logic                rst = 1'b1;
  fct_pkg::fct_ticks_t tk_s = '0;
  fct_pkg::fct_wr_t    wr_s = '0;
  logic [3:0]          rd_a = 4'h0;
  logic                oth = 1'b0;
  logic                go = 1'b0;
  logic                ser_clk;
  logic [7:0]          rd_d;
  logic                pin_o;
  logic                pin_oe;
  int                  error_cnt = 0;
  int                  samples_checked = 0;

  always #2 clk = ~clk;

  fct_host_model u_host (.i_go(go), .o_ser_clk(ser_clk));
  fct_timer #(.REL_FAST_CYC(FAST), .REL_SLOW_CYC(SLOW)) DUT (
    .i_ref_clk(clk), .i_sys_rst(rst), .i_ticks(tk_s), .i_ser_clk(ser_clk),
    .i_wr(wr_s), .i_rd_addr(rd_a), .o_rd_data(rd_d), .i_other_int_low(oth),
    .o_int_n_o(pin_o), .o_int_n_oe(pin_oe));
  ////////////////////////////////
  // Compare, count and report
  task automatic chk(input string nm, input logic [21:0] e, input logic [21:0] s);
    samples_checked++;
    if (s !== e) begin
      $display("mismatch %s expected %0h seen %0h", nm, e, s);
      error_cnt++;
    end
  endtask
  task automatic wr(input logic [3:0] a, input logic [7:0] d);
    @(posedge clk) wr_s <= {1'b1, a, d};
    @(posedge clk) wr_s.en <= 1'b0;
  endtask
  // Read data lands one cycle after the address is taken
  task automatic rd(input logic [3:0] a, input logic [7:0] e);
    @(posedge clk) rd_a <= a;
    @(posedge clk);
    #1 chk($sformatf("reg %h", a), 22'(e), 22'(rd_d));
  endtask
  task automatic tk(input int s, input int n);
    repeat (n) begin
      @(posedge clk) tk_s <= 4'h8 >> s;
      @(posedge clk) tk_s <= 4'h0;
    end
  endtask
  // Stop, arm, stray strobe before the frame, then the frame itself
  task automatic start(input int s);
    wr(fct_pkg::ADDR_EXT, 8'(s));
    wr(fct_pkg::ADDR_EXT, 8'h10 | 8'(s));
    tk(s, 1);
    @(posedge clk) go <= 1'b1;
    @(posedge clk) go <= 1'b0;
    repeat (180) @(posedge clk);
  endtask
  task automatic pin(input logic e);
    repeat (2) @(posedge clk);
    #1 chk("int_n_oe", 22'(e), 22'(pin_oe));
    chk("int_n_o", 22'h0, 22'(pin_o));
  endtask
  // Pin goes low one edge after the event edge and must stay n cycles
  task automatic rel(input int n);
    int c;
    c = 0;
    repeat (1) @(posedge clk);
    #1;
    while (pin_oe === 1'b1 && c < 100) begin
      c++;
      @(posedge clk);
      #1;
    end
    chk("release cycles", 22'(n), 22'(c));
  endtask
  task automatic complete_run();
    $display("checks %0d mismatches %0d", samples_checked, error_cnt);
    if (error_cnt == 0 && samples_checked > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask
  ////////////////////////////////
  initial begin
    repeat (5) @(posedge clk);
    rst <= 1'b0;
    for (int a = 3; a < 16; a++) rd(4'(a), 8'h00);
    wr(fct_pkg::ADDR_PRESET_LO, 8'hA5);
    wr(fct_pkg::ADDR_PRESET_HI, 8'hF3);
    rd(fct_pkg::ADDR_PRESET_HI, 8'hF3);
    rd(fct_pkg::ADDR_PRESET_LO, 8'hA5);
    $display("test registers done");
    // Preset 3 with the storage nibble set; every source in turn
    wr(fct_pkg::ADDR_PRESET_LO, 8'h03);
    wr(fct_pkg::ADDR_PRESET_HI, 8'hF0);
    wr(fct_pkg::ADDR_CTRL, 8'h10);
    for (int s = 0; s < 4; s++) begin
      wr(fct_pkg::ADDR_FLAG, 8'h00);
      start(s);
      rd(fct_pkg::ADDR_EXT, 8'h10 | 8'(s));
      tk(s ^ 1, 3);
      tk(s, 2);
      rd(fct_pkg::ADDR_FLAG, 8'h00);
      tk(s, 1);
      rel(s == 0 ? FAST : SLOW);
      rd(fct_pkg::ADDR_FLAG, 8'h10);
    end
    wr(fct_pkg::ADDR_FLAG, 8'h10);
    rd(fct_pkg::ADDR_FLAG, 8'h10);
    wr(fct_pkg::ADDR_FLAG, 8'h00);
    wr(fct_pkg::ADDR_FLAG, 8'h10);
    rd(fct_pkg::ADDR_FLAG, 8'h00);
    tk(3, 3);
    rel(SLOW);
    $display("test sources done");
    // Restart mid-count begins again from the preset; clear the reload event first
    wr(fct_pkg::ADDR_FLAG, 8'h00);
    start(0);
    tk(0, 2);
    start(0);
    tk(0, 2);
    rd(fct_pkg::ADDR_FLAG, 8'h00);
    tk(0, 1);
    rel(FAST);
    // Stop, flag clear and enable clear each release a held pin
    for (int i = 0; i < 3; i++) begin
      wr(fct_pkg::ADDR_CTRL, 8'h10);
      start(0);
      tk(0, 3);
      pin(1'b1);
      wr(fct_pkg::ADDR_EXT + 4'(i), 8'h00);
      pin(1'b0);
    end
    $display("test release done");
    wr(fct_pkg::ADDR_CTRL, 8'h11);
    for (int s = 0; s < 2; s++) begin
      wr(fct_pkg::ADDR_FLAG, 8'h00);
      start(s);
      tk(s, 3);
      rd(fct_pkg::ADDR_FLAG, (s == 0) ? 8'h10 : 8'h00);
    end
    wr(fct_pkg::ADDR_CTRL, 8'h00);
    start(0);
    tk(0, 3);
    pin(1'b0);
    @(posedge clk) oth <= 1'b1;
    pin(1'b1);
    @(posedge clk) oth <= 1'b0;
    pin(1'b0);
    wr(fct_pkg::ADDR_EXT, 8'h00);
    wr(fct_pkg::ADDR_PRESET_LO, 8'h00);
    wr(fct_pkg::ADDR_PRESET_HI, 8'h00);
    wr(fct_pkg::ADDR_FLAG, 8'h00);
    start(0);
    tk(0, 5);
    rd(fct_pkg::ADDR_FLAG, 8'h00);
    $display("test gating done");
    complete_run();
  end
  // Watchdog well beyond the expected run of about 2900 cycles
  initial begin
    repeat (30000) @(posedge clk);
    error_cnt++;
    $display("mismatch watchdog expected finish seen timeout");
    complete_run();
  end
endmodule
